// *** src/sebs_pkg.sv ***
// Purpose: Shared constants and types for the two-wire serial memory slave.
// Assumes: System clock of 125 MHz; bus clock arrives on its own clock port.
// Notes:   Offsets, field positions, the pointer, byte and mask reset values and the default write-cycle count live here.
package sebs_pkg;

  // Clock rate and the self-timed write cycle.
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned T_WC_MS      = 5;
  localparam int unsigned WC_CYCLES_DF = T_WC_MS * 1000 * CLK_MHZ;

  // Array and page geometry.
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [4:0]  PG_IDX_END = 5'h10;

  // Device-type code; the value is arbitrary.
  localparam logic [3:0] DEV_CODE = 4'h5;

  // Control byte field positions.
  localparam int unsigned CODE_HI = 7;
  localparam int unsigned CODE_LO = 4;
  localparam int unsigned BLK_BIT = 1;
  localparam int unsigned RW_BIT  = 0;

  // Bit slot numbers within one byte frame.
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // Reset values.
  localparam logic [8:0]  PTR_RST  = 9'h000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // Protocol phase of the slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } sebs_phase_t;

  // Programming engine states.
  typedef enum logic [1:0] {
    PG_IDLE,
    PG_COPY,
    PG_WAIT
  } sebs_pg_t;

  // One write into the array.
  typedef struct packed {
    logic       en;
    logic [8:0] addr;
    logic [7:0] data;
  } sebs_wr_t;

endpackage

// *** src/sebs_ram.sv ***
// Purpose: Simple dual-port memory with a registered read port.
// Assumes: One write port and one read port on the same clock.
// Notes:   Used for both the array and the page buffer; contents are not reset.
`timescale 1ns/1ns
module sebs_ram #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [2**AW];

  // Write and registered read; a read of the word being written sees old data.
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule // sebs_ram

// *** src/sebs_top.sv ***
// Purpose: Two-wire bus slave front end of a 512-byte serial memory.
// Assumes: Bus clock is a clock port; SDA is split into in, out and enable.
// Notes:   Protocol runs on sys_clk_in; bus clock only samples data bits.
// Contract
// - Write-protect low: whole array readable and writable.
// - Write-protect high: writes refused, reads normal.
// - Variant without protect pin: always writable.
// - SDA fall with SCL high is start.
// - SDA rise with SCL high is stop.
// - SDA changes only while SCL low.
// - Receiver acknowledges every byte in ninth slot.
// - Acknowledge holds SDA low through SCL high.
// - No acknowledge at all while programming.
// - Master nack ends read; slave releases SDA.
// - Control byte: code, two ignored, block bit.
// - Lowest control bit selects read or write.
// - Matching slave address is acknowledged.
// - Byte after control loads the pointer.
// - Byte write committed by stop.
// - Page buffers 16 bytes until stop.
// - Only low four pointer bits increment; sequential reads step all nine.
// - Write cycle finishes within 5 ms.
// - Pointer holds last address plus one.
// - Address write then repeated start reads.
// - Master ack fetches next sequential byte.
`timescale 1ns/1ns
module sebs_top #(
  parameter int unsigned WC_CYCLES  = sebs_pkg::WC_CYCLES_DF,
  parameter bit          WP_PRESENT = 1'b1
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic scl_clk_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic wp_in,
  output logic      write_busy_out
);

  localparam int unsigned CNT_W    = $clog2(WC_CYCLES + 1);
  localparam int unsigned WAIT_CYC = WC_CYCLES - sebs_pkg::PAGE_BYTES - 2;
  // Bus clock domain.
  logic link_bit;
  logic link_tog;
  // Synchronisers.
  logic [2:0] tog_s;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] wp_s;
  // Protocol state.
  sebs_pkg::sebs_phase_t phase;
  sebs_pkg::sebs_phase_t next_phase;
  logic [3:0]            bit_cnt;
  logic [3:0]            next_bit_cnt;
  logic [7:0]            rx;
  logic [7:0]            next_rx;
  logic [7:0]            tx;
  logic [7:0]            next_tx;
  logic [8:0]            ptr;
  logic [8:0]            next_ptr;
  logic                  blk;
  logic                  next_blk;
  logic                  ack_pend;
  logic                  next_ack;
  logic                  next_oe;
  logic [15:0]           pg_valid;
  logic [15:0]           next_valid;
  logic                  buf_we;
  logic                  commit;
  // Programming engine.
  sebs_pkg::sebs_pg_t pg_st;
  logic [4:0]         pg_idx;
  logic [4:0]         pg_base;
  logic [15:0]        pg_mask;
  logic [CNT_W-1:0]   wc_cnt;
  sebs_pkg::sebs_wr_t mem_wr;
  logic [7:0]         rd_data;
  logic [7:0]         buf_rdata;
  // Decoded bus events.
  wire       rise_evt  = tog_s[2] ^ tog_s[1];
  wire       scl_hi    = scl_s[2] & scl_s[1];
  wire       scl_fall  = scl_s[2] & ~scl_s[1];
  wire       start_det = scl_hi & sda_s[2] & ~sda_s[1];
  wire       stop_det  = scl_hi & ~sda_s[2] & sda_s[1];
  wire       wp_act    = WP_PRESENT & wp_s[1];
  wire       busy      = (pg_st != sebs_pkg::PG_IDLE);
  wire [7:0] rx_byte   = {rx[6:0], link_bit};
  wire       code_ok   = (rx_byte[sebs_pkg::CODE_HI:sebs_pkg::CODE_LO] == sebs_pkg::DEV_CODE);
  wire       active    = (phase != sebs_pkg::ST_IDLE) && (phase != sebs_pkg::ST_IGNORE);
  wire [2:0] tx_idx    = ~bit_cnt[2:0];
  wire [3:0] prev_idx  = pg_idx[3:0] - 4'h1;

  // Each SCL rise samples SDA, then flips a toggle for the system domain.
  // The sampled bit is held for a whole bus period, so it is safe to read
  // once the toggle has crossed.
  always_ff @(posedge scl_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_bit <= 1'b1;
      link_tog <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tog <= ~link_tog;
    end
  end

  // Two-flop synchronisers; the third stage only feeds edge detection.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_s <= 3'h0;
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      wp_s  <= 2'h0;
    end else begin
      tog_s <= {tog_s[1:0], link_tog};
      scl_s <= {scl_s[1:0], scl_clk_in};
      sda_s <= {sda_s[1:0], sda_in};
      wp_s  <= {wp_s[0], wp_in};
    end
  end

  // Protocol next-state logic. Start and stop take priority over bit events
  // so that a start is recognised in any phase.
  always_comb begin
    next_phase   = phase;
    next_bit_cnt = bit_cnt;
    next_rx      = rx;
    next_tx      = tx;
    next_ptr     = ptr;
    next_blk     = blk;
    next_ack     = ack_pend;
    next_oe      = sda_oe_out;
    next_valid   = pg_valid;
    buf_we       = 1'b0;
    commit       = 1'b0;
    if (start_det) begin
      next_phase   = sebs_pkg::ST_CTRL;
      next_bit_cnt = sebs_pkg::BIT_FIRST;
      next_oe      = 1'b0;
      next_ack     = 1'b0;
      next_valid   = sebs_pkg::MASK_RST; // Unstopped data is dropped; pointer kept
    end else if (stop_det) begin
      next_phase = sebs_pkg::ST_IDLE;
      next_oe    = 1'b0;
      next_ack   = 1'b0;
      if (|pg_valid) begin
        next_valid = sebs_pkg::MASK_RST;
        commit     = ~wp_act;
      end
    end else if (active) begin
      if (rise_evt) begin
        // After a read control byte our own ack reads low, fetching the first byte.
        if (bit_cnt == sebs_pkg::BIT_ACK) begin
          next_bit_cnt = sebs_pkg::BIT_FIRST;
          if (phase == sebs_pkg::ST_RDATA) begin
            if (link_bit) begin
              next_phase = sebs_pkg::ST_IGNORE;
            end else begin
              next_tx  = rd_data;
              next_ptr = ptr + 9'h001;
            end
          end
        end else begin
          next_rx      = rx_byte;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == sebs_pkg::BIT_LAST) begin
            case (phase)
              sebs_pkg::ST_CTRL: begin
                if (!code_ok || busy) begin
                  next_phase = sebs_pkg::ST_IGNORE;
                end else if (rx_byte[sebs_pkg::RW_BIT]) begin
                  next_ack   = 1'b1;
                  next_phase = sebs_pkg::ST_RDATA;
                end else begin
                  next_ack   = 1'b1;
                  next_phase = sebs_pkg::ST_ADDR;
                  next_blk   = rx_byte[sebs_pkg::BLK_BIT];
                end
              end
              sebs_pkg::ST_ADDR: begin
                next_ack   = 1'b1;
                next_ptr   = {blk, rx_byte};
                next_phase = sebs_pkg::ST_WDATA;
              end
              sebs_pkg::ST_WDATA: begin
                next_ack   = 1'b1;
                buf_we     = 1'b1;
                next_valid[ptr[3:0]] = 1'b1;
                next_ptr[3:0] = ptr[3:0] + 4'h1;
              end
              default: begin
                next_ack = ack_pend;
              end
            endcase
          end
        end
      end
      if (scl_fall) begin
        if (bit_cnt == sebs_pkg::BIT_ACK) begin
          next_oe  = ack_pend;
          next_ack = 1'b0;
        end else if (phase == sebs_pkg::ST_RDATA) begin
          next_oe = ~tx[tx_idx]; // Open drain: a one releases the line.
        end else begin
          next_oe = 1'b0;
        end
      end
    end
  end

  // Protocol registers.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase      <= sebs_pkg::ST_IDLE;
      bit_cnt    <= sebs_pkg::BIT_FIRST;
      rx         <= sebs_pkg::BYTE_RST;
      tx         <= sebs_pkg::BYTE_RST;
      ptr        <= sebs_pkg::PTR_RST;
      blk        <= 1'b0;
      ack_pend   <= 1'b0;
      sda_oe_out <= 1'b0;
      pg_valid   <= sebs_pkg::MASK_RST;
    end else begin
      phase      <= next_phase;
      bit_cnt    <= next_bit_cnt;
      rx         <= next_rx;
      tx         <= next_tx;
      ptr        <= next_ptr;
      blk        <= next_blk;
      ack_pend   <= next_ack;
      sda_oe_out <= next_oe;
      pg_valid   <= next_valid;
    end
  end

  // The buffer is copied one byte per cycle, then the remaining write time
  // is waited out. Total busy time is trimmed so the whole cycle fits.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pg_st   <= sebs_pkg::PG_IDLE;
      pg_idx  <= 5'h00;
      pg_base <= 5'h00;
      pg_mask <= sebs_pkg::MASK_RST;
      wc_cnt  <= '0;
    end else begin
      case (pg_st)
        sebs_pkg::PG_IDLE: begin
          if (commit) begin
            pg_st   <= sebs_pkg::PG_COPY;
            pg_idx  <= 5'h00;
            pg_base <= ptr[8:4];
            pg_mask <= pg_valid;
          end
        end
        sebs_pkg::PG_COPY: begin
          pg_idx <= pg_idx + 5'h01;
          if (pg_idx == sebs_pkg::PG_IDX_END) begin
            pg_st  <= sebs_pkg::PG_WAIT;
            wc_cnt <= CNT_W'(WAIT_CYC);
          end
        end
        sebs_pkg::PG_WAIT: begin
          wc_cnt <= wc_cnt - CNT_W'(1);
          if (wc_cnt == '0) begin
            pg_st <= sebs_pkg::PG_IDLE;
          end
        end
        default: begin
          pg_st <= sebs_pkg::PG_IDLE;
        end
      endcase
    end
  end
  // Array write from the buffer, one cycle behind its read address.
  wire wr_en = (pg_st == sebs_pkg::PG_COPY) && (pg_idx != 5'h00) && pg_mask[prev_idx];
  assign mem_wr = {wr_en, pg_base, prev_idx, buf_rdata};
  // Constant low drive and the busy flag, both registered.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_out        <= 1'b0;
      write_busy_out <= 1'b0;
    end else begin
      sda_out        <= 1'b0;
      write_busy_out <= busy;
    end
  end

  sebs_ram #(
    .AW (sebs_pkg::ADDR_W),
    .DW (sebs_pkg::DATA_W)
  ) u_array (
    .clk_in    (sys_clk_in),
    .we_in     (mem_wr.en),
    .waddr_in  (mem_wr.addr),
    .wdata_in  (mem_wr.data),
    .raddr_in  (ptr),
    .rdata_out (rd_data)
  );
  sebs_ram #(
    .AW (sebs_pkg::PAGE_W),
    .DW (sebs_pkg::DATA_W)
  ) u_page (
    .clk_in    (sys_clk_in),
    .we_in     (buf_we),
    .waddr_in  (ptr[3:0]),
    .wdata_in  (rx_byte),
    .raddr_in  (pg_idx[3:0]),
    .rdata_out (buf_rdata)
  );
  // Counts the cycles of one busy period for the write-time check.
  logic [CNT_W:0] busy_cnt;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy ? busy_cnt + (CNT_W+1)'(1) : '0;
    end
  end

  AST_NO_ACK_BUSY: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    busy && write_busy_out |-> !sda_oe_out)
    else $error("Line driven during a programming cycle.");
  AST_WP_BLOCKS: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    stop_det && wp_act && !busy |=> !busy [*3])
    else $error("Programming started while protected.");
  AST_START_CTRL: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    start_det |=> (phase == sebs_pkg::ST_CTRL) && (bit_cnt == sebs_pkg::BIT_FIRST))
    else $error("Start did not open a control byte.");
  AST_STOP_IDLE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    stop_det |=> (phase == sebs_pkg::ST_IDLE) && !sda_oe_out && (pg_valid == '0))
    else $error("Stop did not end the transaction.");
  AST_PAGE_WRAP: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    buf_we |=> (ptr[8:4] == $past(ptr[8:4])) && (ptr[3:0] == $past(ptr[3:0]) + 4'h1))
    else $error("Page pointer left its page.");
  AST_SDA_TIMING: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $changed(sda_oe_out) |-> $past(scl_fall || start_det || stop_det))
    else $error("Line changed outside the clock low phase.");
  AST_WC_BOUND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    busy_cnt <= (CNT_W+1)'(WC_CYCLES))
    else $error("Write cycle exceeded its limit.");
  AST_BAD_CODE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    rise_evt && !start_det && !stop_det && (phase == sebs_pkg::ST_CTRL)
      && (bit_cnt == sebs_pkg::BIT_LAST) && !code_ok
      |=> (phase == sebs_pkg::ST_IGNORE) && !ack_pend)
    else $error("Foreign code was not ignored.");
  AST_NACK_END: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    rise_evt && !start_det && !stop_det && (phase == sebs_pkg::ST_RDATA)
      && (bit_cnt == sebs_pkg::BIT_ACK) && link_bit
      |=> (phase == sebs_pkg::ST_IGNORE) ##1 !sda_oe_out)
    else $error("Read did not end after a nack.");

  COV_COMMIT: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    commit ##1 (pg_st == sebs_pkg::PG_COPY));
  COV_SEQ_READ: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    rise_evt && (phase == sebs_pkg::ST_RDATA) && (bit_cnt == sebs_pkg::BIT_ACK) && !link_bit);
  COV_POLL_NACK: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    busy && (phase == sebs_pkg::ST_IGNORE));
  COV_PAGE_FULL: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    stop_det && (pg_valid == 16'hffff));

endmodule // sebs_top

// *** verif/sebs_bus_master.sv ***
// Purpose: Behavioural two-wire bus master that drives the serial memory slave.
// Assumes: The data wire is resolved outside; released, the pull-up makes it high.
// Notes:   The clock stands high between frames; the bench calls the tasks.
`timescale 1ns/1ns
module sebs_bus_master #(
  parameter int unsigned Q_NS = 40
) (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  // The bus starts idle, with clock high and data released.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Start or repeated start; the skew keeps link edges off the system clock phase.
  task automatic start_cond();
    #3;
    sda_low_out = 1'b0;
    #Q_NS scl_out = 1'b1;
    #Q_NS sda_low_out = 1'b1;
    #Q_NS scl_out = 1'b0;
  endtask

  // Stop leaves the bus idle, so the clock stands still until the next frame.
  task automatic stop_cond();
    #Q_NS sda_low_out = 1'b1;
    #Q_NS scl_out = 1'b1;
    #Q_NS sda_low_out = 1'b0;
    #Q_NS;
  endtask

  // Eight bits, most significant first, then the acknowledge slot.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q_NS sda_low_out = ~b[i];
      #Q_NS scl_out = 1'b1;
      #(2*Q_NS) scl_out = 1'b0;
    end
    #Q_NS sda_low_out = 1'b0;
    #Q_NS scl_out = 1'b1;
    #Q_NS ack = ~sda_in;
    #Q_NS scl_out = 1'b0;
  endtask

  // Receives a byte; the acknowledge is held past the clock fall to keep hold time.
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #(2*Q_NS) scl_out = 1'b1;
      #Q_NS b[i] = sda_in;
      #Q_NS scl_out = 1'b0;
    end
    #Q_NS sda_low_out = mack;
    #Q_NS scl_out = 1'b1;
    #(2*Q_NS) scl_out = 1'b0;
    #Q_NS sda_low_out = 1'b0;
  endtask
endmodule // sebs_bus_master

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the two-wire serial memory slave.
// Assumes: Write cycle shortened to WC system cycles through the parameter.
// Notes:   The data wire is resolved here from both open-drain parties.
`timescale 1ns/1ns
module tb_top;
  localparam int WC = 400;
  logic       sys_clk_in;
  logic       reset_n_in;
  logic       wp_in;
  logic       sda_out;
  logic       sda_oe_out;
  logic       write_busy_out;
  wire logic  scl_w;
  wire logic  mlow_w;
  wire logic  sda_w;
  int         error_cnt;
  int         total_checks;
  logic [7:0] exp_mem [0:15];

  // Open-drain wire with pull-up.
  assign sda_w = (sda_oe_out | mlow_w) ? 1'b0 : 1'b1;

  sebs_top #(.WC_CYCLES(WC), .WP_PRESENT(1'b1)) sebs_top_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .scl_clk_in(scl_w),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .wp_in(wp_in), .write_busy_out(write_busy_out));

  sebs_bus_master sebs_bus_master_inst (
    .scl_out(scl_w), .sda_low_out(mlow_w), .sda_in(sda_w));

  // System clock of 8 ns.
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] ctrl(input logic blk, input logic rd);
    return {sebs_pkg::DEV_CODE, 2'b00, blk, rd};
  endfunction

  // Bounded wait for the busy flag; running out ends the run.
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (write_busy_out !== lvl && n < lim) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("MISMATCH write_busy_out expected %b seen timeout", lvl);
      stop_test();
    end
  endtask

  task automatic addr_write(input logic [8:0] a);
    logic ack;
    sebs_bus_master_inst.start_cond();
    sebs_bus_master_inst.send_byte(ctrl(a[8], 1'b0), ack);
    check1("ctrl_ack", 1'b1, ack);
    sebs_bus_master_inst.send_byte(a[7:0], ack);
    check1("addr_ack", 1'b1, ack);
  endtask

  task automatic rd_one(input string name, input logic [7:0] exp);
    logic       ack;
    logic [7:0] d;
    sebs_bus_master_inst.start_cond();
    sebs_bus_master_inst.send_byte(ctrl(1'b1, 1'b1), ack);
    check1("rd_ctrl_ack", 1'b1, ack);
    sebs_bus_master_inst.recv_byte(1'b0, d);
    check8(name, exp, d);
    sebs_bus_master_inst.stop_cond();
  endtask

  // Page write of 18 bytes wraps in the page, then a sequential read of it.
  task automatic s_page();
    logic       ack;
    logic [7:0] d;
    int         n;
    addr_write(9'h1fc);
    for (int i = 0; i < 18; i++) begin
      sebs_bus_master_inst.send_byte(8'h40 + 8'(i), ack);
      exp_mem[4'hc + 4'(i)] = 8'h40 + 8'(i);
      check1("data_ack", 1'b1, ack);
    end
    check1("busy_before_stop", 1'b0, write_busy_out);
    sebs_bus_master_inst.stop_cond();
    wait_busy(1'b1, 8, n);
    wait_busy(1'b0, WC + 8, n);
    check1("busy_length", 1'b1, n >= WC - 8);
    addr_write(9'h1f0);
    sebs_bus_master_inst.start_cond();
    sebs_bus_master_inst.send_byte(ctrl(1'b1, 1'b1), ack);
    check1("seq_ctrl_ack", 1'b1, ack);
    for (int k = 0; k < 16; k++) begin
      sebs_bus_master_inst.recv_byte(k != 15, d);
      check8("seq_data", exp_mem[k], d);
    end
    repeat (2) @(negedge sys_clk_in);
    check1("oe_after_nack", 1'b0, sda_oe_out);
    check1("sda_out_low", 1'b0, sda_out);
    sebs_bus_master_inst.stop_cond();
  endtask

  // Byte write, acknowledge polling while busy, random and current reads.
  task automatic s_byte();
    logic ack;
    int   n;
    addr_write(9'h1ff);
    sebs_bus_master_inst.send_byte(8'ha5, ack);
    check1("byte_ack", 1'b1, ack);
    sebs_bus_master_inst.stop_cond();
    wait_busy(1'b1, 8, n);
    sebs_bus_master_inst.start_cond();
    sebs_bus_master_inst.send_byte(ctrl(1'b1, 1'b0), ack);
    check1("poll_ack", 1'b0, ack);
    check1("busy_at_poll", 1'b1, write_busy_out);
    sebs_bus_master_inst.stop_cond();
    wait_busy(1'b0, WC + 8, n);
    exp_mem[15] = 8'ha5;
    addr_write(9'h1fe);
    rd_one("random_data", exp_mem[14]);
    rd_one("current_data", 8'ha5);
  endtask

  // Protected write is acknowledged but changes nothing; reads still work.
  task automatic s_wp();
    logic ack;
    @(negedge sys_clk_in);
    wp_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    addr_write(9'h1f3);
    sebs_bus_master_inst.send_byte(8'h00, ack);
    check1("wp_data_ack", 1'b1, ack);
    sebs_bus_master_inst.stop_cond();
    repeat (20) @(negedge sys_clk_in);
    check1("wp_no_busy", 1'b0, write_busy_out);
    addr_write(9'h1f3);
    rd_one("wp_keep", exp_mem[3]);
    @(negedge sys_clk_in);
    wp_in = 1'b0;
  endtask

  // Wrong device code is ignored until the next start.
  task automatic s_bad();
    logic ack;
    sebs_bus_master_inst.start_cond();
    sebs_bus_master_inst.send_byte({sebs_pkg::DEV_CODE ^ 4'h3, 4'h0}, ack);
    check1("bad_ctrl_ack", 1'b0, ack);
    sebs_bus_master_inst.send_byte(8'h12, ack);
    check1("bad_next_ack", 1'b0, ack);
    sebs_bus_master_inst.stop_cond();
    rd_one("after_bad", exp_mem[4]);
  endtask

  // Bound on the whole run.
  initial begin
    #400000;
    error_cnt++;
    $display("MISMATCH run_time expected finish seen timeout");
    stop_test();
  end

  // Main sequence: reset held for five cycles, then the scenarios.
  initial begin
    error_cnt = 0;
    total_checks = 0;
    reset_n_in = 1'b0;
    wp_in = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    s_page();
    s_byte();
    s_wp();
    s_bad();
    stop_test();
  end
endmodule // tb_top
